//--- arx_receive_status.sv
// Receive status, FIFO, diagnostics and sample counters
//
// Behaviour
// RULE1: Overflow and sync-error flags set on their event and stay set.
// RULE2: Writing one clears a flag; interrupt drops unless another is pending.
// RULE3: Interrupt only when flag, its enable and bridge enable all set.
// RULE4: Flags latch even while their interrupt enable is off.
// RULE5: Two-bit field reports 188, 204 or out-of-sync reception.
// RULE6: Static four-bit field reports buffer memory size code.
// RULE7: Overflow flag sets when a word cannot be stored.
// RULE8: Sync-error flag sets on packet synchronisation loss.
// RULE9: Carrier bit reads one only with carrier and locked input loop.
// RULE10: Lock bit follows the input clock-recovery lock.
// RULE11: Rate bit drops when input rate falls under about 900 bit/s.
// RULE12: Polarity bit shows detector in auto, else the forced setting.
// RULE13: Load register reports FIFO occupancy in bytes, bits 23 to 0.
// RULE14: FIFO capacity is memory size plus pipeline storage.
// RULE15: Loop-back mode disconnects the serial input from the FIFO.
// RULE16: Loop-back byte write pushes only in loop-back mode.
// RULE17: Memory-full flag blocks writes and drops arriving bytes.
// RULE18: Rate-overflow flag shows bytes arriving faster than writes.
// RULE19: Soft reset clears the whole diagnostics register; code clears loop-back and rate-overflow bits, memory-full bit stays.
// RULE20: Valid-byte counter sampled once per period at its half.
// RULE21: Violation counter counts illegal code words, sample readable.
// RULE22: Clear-FIFO and receive-reset are self-clearing pulses.
// RULE23: Polarity control 00 auto, 10 normal, 11 inverted.
// RULE24: Clear-FIFO zeroes load, clears overflow, requests idle.
// RULE25: Both samples update together in one cycle.
// RULE26: Data window read returns oldest word and pops it.
`timescale 1ns/1ps
module arx_receive_status #(
    parameter int          FIFO_WORDS    = 16,
    parameter logic [3:0]  MEMORY_CODE   = arx_pkg::MEM_SIZE_8MB,
    parameter longint      RATE_TIMEOUT  = arx_pkg::RATE_TIMEOUT_CYCLES,
    parameter longint      SAMPLE_PERIOD = arx_pkg::SAMPLE_PERIOD_CYCLES
) (
    // Clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      sys_rst,
    // Register port
    input  wire arx_pkg::arx_reg_req_type  reg_req,
    output logic [31:0]                    reg_rdata,
    output logic                           reg_rvalid,
    // Input circuitry
    input  wire logic                      carrier_pin,
    input  wire logic                      pll_lock_pin,
    input  wire arx_pkg::arx_byte_type     byte_in,
    output logic                           byte_ready,
    input  wire arx_pkg::arx_rx_event_type rx_event,
    // Receive control block
    input  wire arx_pkg::arx_ctrl_type     ctrl,
    output logic                           rx_idle_pulse,
    output logic                           irq
);
    localparam int PTR_W = $clog2(FIFO_WORDS);
    localparam int CNT_W = $clog2(FIFO_WORDS + 1);
    localparam logic [CNT_W-1:0] FULL_WORDS = CNT_W'(FIFO_WORDS);
    localparam logic [31:0] RATE_LIMIT = 32'(RATE_TIMEOUT);
    localparam logic [31:0] PHASE_LAST = 32'(SAMPLE_PERIOD - 1);
    localparam logic [31:0] PHASE_HALF = 32'(SAMPLE_PERIOD / 2);
    localparam int FIFO_LOAD_W    = arx_pkg::FIFO_LOAD_W;
    localparam int FIFO_LOAD_W_HI = FIFO_LOAD_W - 1;

    typedef struct packed {
        logic                          cd_meta;
        logic                          cd_sync;
        logic                          lock_meta;
        logic                          lock_sync;
        logic [1:0]                    pkt_status;
        logic                          inv_status;
        logic                          rate_ok;
        logic [31:0]                   idle_cnt;
        logic                          ovf_flag;
        logic                          sync_flag;
        logic                          mode_a;
        logic                          rate_ovf;
        logic [1:0][7:0]               buf_byte;
        logic [1:0]                    buf_cnt;
        logic                          in_ready;
        logic [31:0]                   pack_word;
        logic [1:0]                    pack_cnt;
        logic                          commit;
        logic [FIFO_WORDS-1:0][31:0]   mem;
        logic [PTR_W-1:0]              wptr;
        logic [PTR_W-1:0]              rptr;
        logic [CNT_W-1:0]              words;
        logic [31:0]                   valid_cnt;
        logic [31:0]                   viol_cnt;
        logic [31:0]                   valid_sample;
        logic [31:0]                   viol_sample;
        logic [31:0]                   phase;
        logic [31:0]                   rdata;
        logic                          rvalid;
        logic                          idle_pulse;
        logic                          irq;
    } arx_state_type;

    arx_state_type s;
    arx_state_type next_s;

    logic lb_wr;
    logic data_rd;
    logic status_wr;
    assign lb_wr     = reg_req.wr && reg_req.addr == arx_pkg::OFS_MODE_A;
    assign status_wr = reg_req.wr && reg_req.addr == arx_pkg::OFS_STATUS;
    assign data_rd   = reg_req.rd && reg_req.addr >= arx_pkg::OFS_DATA_LO
                       && reg_req.addr <= arx_pkg::OFS_DATA_HI;

    always_comb begin
        logic             src_valid;
        logic [7:0]       src_byte;
        logic             full;
        logic             pop_buf;
        logic             drop_word;
        logic             clr;
        logic [31:0]      st;
        logic [31:0]      load;
        logic [CNT_W-1:0] wcount;
        src_valid = 1'b0;
        src_byte  = 8'h00;
        full      = 1'b0;
        pop_buf   = 1'b0;
        drop_word = 1'b0;
        clr       = 1'b0;
        st        = 32'h0000_0000;
        load      = 32'h0000_0000;
        wcount    = s.words;
        next_s    = s;

        // Pin synchronisers
        next_s.cd_meta   = carrier_pin;
        next_s.cd_sync   = s.cd_meta;
        next_s.lock_meta = pll_lock_pin;
        next_s.lock_sync = s.lock_meta;

        next_s.pkt_status = rx_event.packet_length_status; // RULE5
        if (ctrl.polarity_ctl == arx_pkg::POL_NORMAL ||
            ctrl.polarity_ctl == arx_pkg::POL_INVERT) begin
            next_s.inv_status = ctrl.polarity_ctl[0]; // RULE12 RULE23
        end else begin
            next_s.inv_status = rx_event.polarity_detected_inv; // RULE12
        end

        // Activity watchdog: a byte per timeout is the slowest rate
        if (byte_in.valid) begin
            next_s.idle_cnt = 32'h0000_0000;
        end else if (s.idle_cnt < RATE_LIMIT) begin
            next_s.idle_cnt = s.idle_cnt + 32'h0000_0001;
        end
        next_s.rate_ok = next_s.idle_cnt < RATE_LIMIT; // RULE11

        // Free-running counters and their joint sample
        if (byte_in.valid && !byte_in.stuffing) begin
            next_s.valid_cnt = s.valid_cnt + 32'h0000_0001; // RULE20
        end
        if (rx_event.code_violation) begin
            next_s.viol_cnt = s.viol_cnt + 32'h0000_0001; // RULE21
        end
        next_s.phase = (s.phase == PHASE_LAST) ? 32'h0000_0000
                                               : s.phase + 32'h0000_0001;
        if (s.phase == PHASE_HALF) begin
            next_s.valid_sample = s.valid_cnt; // RULE20 RULE25
            next_s.viol_sample  = s.viol_cnt;  // RULE21 RULE25
        end

        // Oldest word leaves through the data window
        if (data_rd && s.words != '0) begin
            next_s.rptr = s.rptr + PTR_W'(1); // RULE26
            wcount      = wcount - CNT_W'(1);
        end

        // Packed word enters memory one cycle after its fourth byte
        next_s.commit = 1'b0;
        if (s.commit) begin
            if (wcount < FULL_WORDS) begin
                next_s.mem[s.wptr] = s.pack_word;
                next_s.wptr        = s.wptr + PTR_W'(1);
                wcount             = wcount + CNT_W'(1);
            end else begin
                drop_word = 1'b1; // RULE17
            end
        end
        next_s.words = wcount;
        full = s.words == FULL_WORDS; // RULE14

        // Source select: serial path is cut off in loop-back mode
        if (s.mode_a) begin
            src_valid = lb_wr; // RULE15 RULE16
            src_byte  = reg_req.wdata[arx_pkg::LB_BYTE_LSB +: 8];
        end else begin
            src_valid = byte_in.valid && !byte_in.stuffing && ctrl.rx_enable;
            src_byte  = byte_in.data;
        end
        drop_word = drop_word || (src_valid && full); // RULE7 RULE17

        // Two-entry buffer; commit stores the old word, packer never stalls
        pop_buf = s.buf_cnt != 2'h0;
        if (pop_buf) begin
            next_s.buf_byte[0] = s.buf_byte[1];
            next_s.buf_cnt     = s.buf_cnt - 2'h1;
            next_s.pack_word[s.pack_cnt*8 +: 8] = s.buf_byte[0];
            next_s.pack_cnt    = s.pack_cnt + 2'h1;
            next_s.commit      = s.pack_cnt == 2'h3;
        end
        if (src_valid && !full) begin // RULE17
            if (s.in_ready) begin
                next_s.buf_byte[next_s.buf_cnt[0]] = src_byte;
                next_s.buf_cnt = next_s.buf_cnt + 2'h1;
            end else begin
                next_s.rate_ovf = 1'b1; // RULE18
            end
        end

        // Register writes: write-one clears, then hardware sets win
        if (status_wr && reg_req.wdata[arx_pkg::ST_OVF_BIT]) begin
            next_s.ovf_flag = 1'b0; // RULE2
        end
        if (status_wr && reg_req.wdata[arx_pkg::ST_SYNC_BIT]) begin
            next_s.sync_flag = 1'b0; // RULE2
        end
        if (reg_req.wr && reg_req.addr == arx_pkg::OFS_DIAG) begin
            next_s.mode_a = reg_req.wdata[arx_pkg::DG_LOOP_BIT];
            if (reg_req.wdata[arx_pkg::DG_ROVF_BIT]) begin
                next_s.rate_ovf = 1'b0;
            end
            if (src_valid && !full && !s.in_ready) begin
                next_s.rate_ovf = 1'b1;
            end
        end
        if (drop_word) begin
            next_s.ovf_flag = 1'b1; // RULE1 RULE4 RULE7
        end
        if (rx_event.sync_error) begin
            next_s.sync_flag = 1'b1; // RULE1 RULE4 RULE8
        end

        // Clear actions are pulses; they override pending data
        next_s.idle_pulse = 1'b0;
        clr = ctrl.clear_fifo_pulse || ctrl.receive_reset_pulse; // RULE22
        if (clr) begin
            next_s.words      = '0; // RULE24
            next_s.wptr       = '0;
            next_s.rptr       = '0;
            next_s.buf_cnt    = 2'h0;
            next_s.pack_cnt   = 2'h0;
            next_s.commit     = 1'b0;
            next_s.ovf_flag   = 1'b0; // RULE24
            next_s.idle_pulse = 1'b1; // RULE24
        end
        if (ctrl.receive_reset_pulse) begin
            next_s.sync_flag = 1'b0;
        end
        if (ctrl.soft_reset) begin
            next_s.mode_a   = 1'b0; // RULE19
            next_s.rate_ovf = 1'b0; // RULE19
        end
        next_s.in_ready = next_s.buf_cnt != 2'h2;

        next_s.irq = ctrl.bridge_int_en && // RULE3
                     ((next_s.ovf_flag && ctrl.ovf_int_en) ||
                      (next_s.sync_flag && ctrl.sync_int_en)); // RULE2

        // Read mux
        st[arx_pkg::ST_PKT_LSB +: 2]  = s.pkt_status;  // RULE5
        st[arx_pkg::ST_SIZE_LSB +: 4] = MEMORY_CODE;   // RULE6
        st[arx_pkg::ST_OVF_BIT]       = s.ovf_flag;
        st[arx_pkg::ST_SYNC_BIT]      = s.sync_flag;
        st[arx_pkg::ST_CD_BIT]        = s.cd_sync && s.lock_sync; // RULE9
        st[arx_pkg::ST_LOCK_BIT]      = s.lock_sync;   // RULE10
        st[arx_pkg::ST_RATE_BIT]      = s.rate_ok;     // RULE11
        st[arx_pkg::ST_INV_BIT]       = s.inv_status;  // RULE12
        load[FIFO_LOAD_W_HI:0] = FIFO_LOAD_W'({s.words, 2'b00}) +
                                 FIFO_LOAD_W'(s.pack_cnt) +
                                 FIFO_LOAD_W'({s.commit, 2'b00}); // RULE13
        next_s.rvalid = reg_req.rd;
        next_s.rdata  = 32'h0000_0000;
        if (reg_req.rd) begin
            if (reg_req.addr == arx_pkg::OFS_STATUS) begin
                next_s.rdata = st;
            end else if (reg_req.addr == arx_pkg::OFS_FIFO_LOAD) begin
                next_s.rdata = load;
            end else if (reg_req.addr == arx_pkg::OFS_DIAG) begin
                next_s.rdata[arx_pkg::DG_LOOP_BIT] = s.mode_a;
                next_s.rdata[arx_pkg::DG_ROVF_BIT] = s.rate_ovf;
                next_s.rdata[arx_pkg::DG_FULL_BIT] = full; // RULE17
            end else if (reg_req.addr == arx_pkg::OFS_VALID) begin
                next_s.rdata = s.valid_sample;
            end else if (reg_req.addr == arx_pkg::OFS_VIOL) begin
                next_s.rdata = s.viol_sample;
            end else if (data_rd && s.words != '0) begin
                next_s.rdata = s.mem[s.rptr]; // RULE26
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata     = s.rdata;
    assign reg_rvalid    = s.rvalid;
    assign byte_ready    = s.in_ready;
    assign rx_idle_pulse = s.idle_pulse;
    assign irq           = s.irq;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    logic clr_any;
    assign clr_any = ctrl.clear_fifo_pulse || ctrl.receive_reset_pulse;

    ovf_flag_sticky_a: assert property ( // RULE1
        s.ovf_flag && !(status_wr && reg_req.wdata[arx_pkg::ST_OVF_BIT])
        && !clr_any |=> s.ovf_flag)
        else $error("overflow flag dropped without a clear");
    flag_write_clear_a: assert property ( // RULE2
        s.sync_flag && status_wr && reg_req.wdata[arx_pkg::ST_SYNC_BIT]
        && !rx_event.sync_error |=> !s.sync_flag)
        else $error("sync flag not cleared by write of one");
    irq_gate_a: assert property ( // RULE3
        !ctrl.bridge_int_en || !(ctrl.ovf_int_en || ctrl.sync_int_en)
        |=> !irq)
        else $error("interrupt raised while not enabled");
    flag_latch_a: assert property ( // RULE4
        rx_event.sync_error && !ctrl.sync_int_en && !ctrl.receive_reset_pulse
        |=> s.sync_flag)
        else $error("sync flag failed to latch while disabled");
    carrier_lock_a: assert property ( // RULE9
        s.cd_sync && s.lock_sync && reg_req.rd
        && reg_req.addr == arx_pkg::OFS_STATUS
        |=> reg_rvalid && reg_rdata[arx_pkg::ST_CD_BIT]
            && reg_rdata[arx_pkg::ST_LOCK_BIT])
        else $error("carrier or lock bit wrong on status read");
    polarity_force_a: assert property ( // RULE23
        ctrl.polarity_ctl == arx_pkg::POL_INVERT ##1
        ctrl.polarity_ctl == arx_pkg::POL_NORMAL |-> s.inv_status ##1
        !s.inv_status)
        else $error("forced polarity not copied to status");
    loop_isolate_a: assert property ( // RULE15
        s.mode_a && !lb_wr && s.buf_cnt == 2'h0 |=> s.buf_cnt == 2'h0)
        else $error("serial byte entered FIFO in loop-back mode");
    loop_ignore_a: assert property ( // RULE16
        !s.mode_a && lb_wr && !byte_in.valid && s.buf_cnt == 2'h0
        |=> s.buf_cnt == 2'h0)
        else $error("loop-back write stored outside loop-back mode");
    full_drop_a: assert property ( // RULE17
        s.words == FULL_WORDS && byte_in.valid && !byte_in.stuffing
        && ctrl.rx_enable && !s.mode_a && !data_rd && !clr_any
        |=> s.ovf_flag && s.words == FULL_WORDS)
        else $error("word stored or not flagged while memory full");
    clear_fifo_a: assert property ( // RULE24
        ctrl.clear_fifo_pulse |=> s.words == '0 && !s.ovf_flag
        && rx_idle_pulse ##1 !rx_idle_pulse || $past(clr_any))
        else $error("clear action incomplete");
    sample_pair_a: assert property ( // RULE25
        s.phase == PHASE_HALF |=> s.valid_sample == $past(s.valid_cnt)
        && s.viol_sample == $past(s.viol_cnt))
        else $error("samples not taken together");
    viol_count_a: assert property ( // RULE21
        rx_event.code_violation |=> s.viol_cnt == $past(s.viol_cnt) + 1)
        else $error("violation counter missed an event");
    data_pop_a: assert property ( // RULE26
        data_rd && s.words != '0 && !s.commit && !clr_any
        |=> s.words == $past(s.words) - 1)
        else $error("data read did not pop a word");

    mode_a_push_c: cover property (s.mode_a && lb_wr ##[1:4] s.commit);
    overflow_c: cover property (!s.ovf_flag ##1 s.ovf_flag);
    sample_c: cover property (s.phase == PHASE_HALF && s.valid_cnt != 0);
    irq_c: cover property (!irq ##1 irq);

endmodule : arx_receive_status

//--- arx_pkg.sv
// Shared constants and port carriers of the receive status block
package arx_pkg;

    // Register offsets (byte addresses on the local register port)
    localparam logic [7:0] OFS_STATUS    = 8'h08;
    localparam logic [7:0] OFS_FIFO_LOAD = 8'h18;
    localparam logic [7:0] OFS_DIAG      = 8'h1c;
    localparam logic [7:0] OFS_MODE_A  = 8'h20;
    localparam logic [7:0] OFS_VALID     = 8'h30;
    localparam logic [7:0] OFS_VIOL      = 8'h34;
    localparam logic [7:0] OFS_DATA_LO   = 8'h40;
    localparam logic [7:0] OFS_DATA_HI   = 8'h7c;

    // Field positions of receive_status
    localparam int ST_PKT_LSB  = 0;
    localparam int ST_SIZE_LSB = 4;
    localparam int ST_OVF_BIT  = 9;
    localparam int ST_SYNC_BIT = 10;
    localparam int ST_CD_BIT   = 14;
    localparam int ST_LOCK_BIT = 15;
    localparam int ST_RATE_BIT = 16;
    localparam int ST_INV_BIT  = 17;

    // Field positions of receive_diagnostics, loop-back byte and load width
    localparam int DG_LOOP_BIT  = 0;
    localparam int DG_ROVF_BIT  = 9;
    localparam int DG_FULL_BIT  = 10;
    localparam int LB_BYTE_LSB  = 0;
    localparam int FIFO_LOAD_W  = 24;

    // Packet length status codes
    localparam logic [1:0] SHORT_PACKET_CODE = 2'h0;
    localparam logic [1:0] LONG_PACKET_CODE  = 2'h1;
    localparam logic [1:0] OUT_OF_SYNC_CODE  = 2'h3;

    // Polarity control codes
    localparam logic [1:0] POL_AUTO   = 2'h0;
    localparam logic [1:0] POL_NORMAL = 2'h2;
    localparam logic [1:0] POL_INVERT = 2'h3;

    // Buffer memory size codes
    localparam logic [3:0] MEM_SIZE_8MB  = 4'h0;
    localparam logic [3:0] MEM_SIZE_16MB = 4'h1;
    localparam logic [3:0] MEM_SIZE_32MB = 4'h2;

    // Timing
    localparam longint CLK_HZ        = 50_000_000;
    localparam longint RATE_MIN_BPS  = 900;
    localparam longint BITS_PER_BYTE = 8;
    localparam longint RATE_TIMEOUT_CYCLES =
        CLK_HZ * BITS_PER_BYTE / RATE_MIN_BPS;
    localparam longint SAMPLE_PERIOD_CYCLES = 64'h20_0000;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [31:0] wdata;
    } arx_reg_req_type;

    typedef struct packed {
        logic       valid;
        logic       stuffing;
        logic [7:0] data;
    } arx_byte_type;

    typedef struct packed {
        logic [1:0] packet_length_status;
        logic       polarity_detected_inv;
        logic       sync_error;
        logic       code_violation;
    } arx_rx_event_type;

    typedef struct packed {
        logic       rx_enable;
        logic       ovf_int_en;
        logic       sync_int_en;
        logic       bridge_int_en;
        logic [1:0] polarity_ctl;
        logic       clear_fifo_pulse;
        logic       receive_reset_pulse;
        logic       soft_reset;
    } arx_ctrl_type;

endpackage : arx_pkg

//--- arx_host_model.sv
// Host-side register master standing in for the bus bridge
`timescale 1ns/1ps
module arx_host_model (
    // Clock
    input  wire logic                ref_clk,
    // Register port
    output arx_pkg::arx_reg_req_type reg_req,
    input  wire logic [31:0]         reg_rdata,
    input  wire logic                reg_rvalid
);
    initial reg_req = '0;

    // Strobes rise just after an edge and stand for exactly one cycle
    task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        #1 reg_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge ref_clk);
        #1 reg_req = '0;
    endtask : write_reg

    // Answer stands one cycle only, so it is taken as soon as it settles
    task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
        d = 32'hdead_beef;
        @(posedge ref_clk);
        #1 reg_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
        @(posedge ref_clk);
        #1 reg_req = '0;
        repeat (4) begin
            if (reg_rvalid === 1'b1) begin
                d = reg_rdata;
                break;
            end
            @(posedge ref_clk);
            #1;
        end
    endtask : read_reg
endmodule : arx_host_model

//--- asi_receive_status_counters_test.sv
// Self-checking bench of the receive status block
`timescale 1ns/1ps
module asi_receive_status_counters_test;
    logic                      ref_clk      = 1'b0;
    logic                      sys_rst      = 1'b1;
    logic                      carrier_pin  = 1'b0;
    logic                      pll_lock_pin = 1'b0;
    arx_pkg::arx_byte_type     byte_in      = '0;
    arx_pkg::arx_rx_event_type rx_event     = '0;
    arx_pkg::arx_ctrl_type     ctrl         = '0;
    arx_pkg::arx_reg_req_type  reg_req;
    logic [31:0]               reg_rdata;
    logic                      reg_rvalid, byte_ready, rx_idle_pulse, irq;
    int                        fail_count = 0;
    int                        cmp_count  = 0;
    int                        seed       = 32'h7649;
    int                        idle_seen  = 0;
    int                        i0;
    logic [31:0]               d, va, vi;
    logic [7:0]                b [4];
    logic [2:0]                r;
    logic [1:0]                pkc [3];
    logic [1:0]                polc [3];

    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (rx_idle_pulse === 1'b1) idle_seen++;

    arx_host_model i_arx_host_model (.ref_clk(ref_clk), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    // Short rate timeout and sample period keep the run brief
    arx_receive_status #(.RATE_TIMEOUT(50), .SAMPLE_PERIOD(64),
        .MEMORY_CODE(arx_pkg::MEM_SIZE_16MB))
    i_arx_receive_status (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .carrier_pin(carrier_pin), .pll_lock_pin(pll_lock_pin),
        .byte_in(byte_in), .byte_ready(byte_ready), .rx_event(rx_event),
        .ctrl(ctrl), .rx_idle_pulse(rx_idle_pulse), .irq(irq));

    task automatic close_out();
        if (fail_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc

    task automatic rdm(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
        logic [31:0] x;
        i_arx_host_model.read_reg(a, x);
        chk(x & m, e);
    endtask : rdm

    task automatic send(input int n, input logic stuff);
        repeat (n) begin
            byte_in = '{valid: 1'b1, stuffing: stuff, data: 8'($random(seed))};
            cyc(1);
        end
        byte_in = '0;
    endtask : send

    function automatic logic [31:0] st_exp(logic [1:0] pk, logic [1:0] pc,
                                           logic [2:0] rr);
        logic inv;
        inv = (pc == arx_pkg::POL_AUTO) ? rr[0] : pc[0];
        return {14'h0, inv, 1'b0, rr[2], rr[1] & rr[2], 12'h0, pk};
    endfunction : st_exp

    initial begin
        #400000;
        fail_count++;
        close_out();
    end

    initial begin
        pkc  = '{arx_pkg::SHORT_PACKET_CODE, arx_pkg::LONG_PACKET_CODE,
                 arx_pkg::OUT_OF_SYNC_CODE};
        polc = '{arx_pkg::POL_AUTO, arx_pkg::POL_INVERT, arx_pkg::POL_NORMAL};
        cyc(20);
        sys_rst = 1'b0;
        cyc(2);
        i_arx_host_model.write_reg(arx_pkg::OFS_DIAG, 32'h0);
        rdm(arx_pkg::OFS_STATUS, 32'hfffe_ffff,
            {24'h0, arx_pkg::MEM_SIZE_16MB, 4'h0});
        rdm(8'h0c, 32'hffff_ffff, 32'h0);
        for (int i = 0; i < 6; i++) begin
            r = 3'($random(seed));
            rx_event.packet_length_status  = pkc[i % 3];
            rx_event.polarity_detected_inv = r[0];
            ctrl.polarity_ctl = polc[(i / 2) % 3];
            carrier_pin  = r[1];
            pll_lock_pin = r[2];
            cyc(4);
            rdm(arx_pkg::OFS_STATUS, 32'h0002_c003,
                st_exp(pkc[i % 3], polc[(i / 2) % 3], r));
        end
        rx_event = '0;
        ctrl.rx_enable = 1'b1;
        // Loop-back: serial bytes must stay out, host bytes go in
        i_arx_host_model.write_reg(arx_pkg::OFS_MODE_A, 32'h5a);
        i_arx_host_model.write_reg(arx_pkg::OFS_DIAG, 32'h1);
        send(3, 1'b0);
        cyc(4);
        rdm(arx_pkg::OFS_FIFO_LOAD, 32'hffff_ffff, 32'h0);
        for (int i = 0; i < 4; i++) begin
            b[i] = 8'($random(seed));
            i_arx_host_model.write_reg(arx_pkg::OFS_MODE_A, {24'h0, b[i]});
        end
        cyc(4);
        rdm(arx_pkg::OFS_FIFO_LOAD, 32'hffff_ffff, 32'h4);
        rdm(arx_pkg::OFS_DATA_LO, 32'hffff_ffff,
            {b[3], b[2], b[1], b[0]});
        rdm(arx_pkg::OFS_DATA_HI, 32'hffff_ffff, 32'h0);
        rdm(arx_pkg::OFS_FIFO_LOAD, 32'hffff_ffff, 32'h0);
        ctrl.soft_reset = 1'b1;
        cyc(1);
        ctrl.soft_reset = 1'b0;
        rdm(arx_pkg::OFS_DIAG, 32'h0000_0201, 32'h0);
        // Counters: quiet span, burst of events, quiet span past a sample
        cyc(70);
        i_arx_host_model.read_reg(arx_pkg::OFS_VALID, va);
        i_arx_host_model.read_reg(arx_pkg::OFS_VIOL, vi);
        send(8, 1'b0);
        send(3, 1'b1);
        rdm(arx_pkg::OFS_STATUS, 32'h0001_0000, 32'h0001_0000);
        repeat (5) begin
            rx_event.code_violation = 1'b1;
            cyc(1);
            rx_event.code_violation = 1'b0;
            cyc(1);
        end
        cyc(70);
        rdm(arx_pkg::OFS_STATUS, 32'h0001_0000, 32'h0);
        i_arx_host_model.read_reg(arx_pkg::OFS_VALID, d);
        chk(d - va, 32'h8);
        i_arx_host_model.read_reg(arx_pkg::OFS_VIOL, d);
        chk(d - vi, 32'h5);
        rdm(arx_pkg::OFS_FIFO_LOAD, 32'hffff_ffff, 32'h8);
        rdm(arx_pkg::OFS_DIAG, 32'h0000_0200, 32'h0);
        chk({31'h0, byte_ready}, 32'h1);
        // Fill past capacity; nobody drains it
        send(90, 1'b0);
        cyc(4);
        rdm(arx_pkg::OFS_DIAG, 32'h0000_0400, 32'h0000_0400);
        rdm(arx_pkg::OFS_STATUS, 32'h0000_0200, 32'h0000_0200);
        i_arx_host_model.read_reg(arx_pkg::OFS_FIFO_LOAD, d);
        send(8, 1'b0);
        cyc(4);
        rdm(arx_pkg::OFS_FIFO_LOAD, 32'hffff_ffff, d);
        chk({31'h0, irq}, 32'h0);
        ctrl.ovf_int_en = 1'b1;
        ctrl.bridge_int_en = 1'b1;
        cyc(2);
        chk({31'h0, irq}, 32'h1);
        i0 = idle_seen;
        ctrl.clear_fifo_pulse = 1'b1;
        cyc(1);
        ctrl.clear_fifo_pulse = 1'b0;
        cyc(3);
        chk(32'(idle_seen - i0), 32'h1);
        chk({31'h0, irq}, 32'h0);
        rdm(arx_pkg::OFS_FIFO_LOAD, 32'hffff_ffff, 32'h0);
        rdm(arx_pkg::OFS_STATUS, 32'h0000_0200, 32'h0);
        // Sync flag latches while its enable is off
        rx_event.sync_error = 1'b1;
        cyc(1);
        rx_event.sync_error = 1'b0;
        cyc(3);
        rdm(arx_pkg::OFS_STATUS, 32'h0000_0400, 32'h0000_0400);
        chk({31'h0, irq}, 32'h0);
        ctrl.sync_int_en = 1'b1;
        cyc(2);
        chk({31'h0, irq}, 32'h1);
        i_arx_host_model.write_reg(arx_pkg::OFS_STATUS, 32'h0000_0400);
        cyc(2);
        chk({31'h0, irq}, 32'h0);
        rdm(arx_pkg::OFS_STATUS, 32'h0000_0400, 32'h0);
        rx_event.sync_error = 1'b1;
        cyc(1);
        rx_event.sync_error = 1'b0;
        ctrl.receive_reset_pulse = 1'b1;
        cyc(1);
        ctrl.receive_reset_pulse = 1'b0;
        rdm(arx_pkg::OFS_STATUS, 32'h0000_0400, 32'h0);
        close_out();
    end
endmodule : asi_receive_status_counters_test
